// ### logic/vspm_pkg.sv
/*
 Package for the virtual status port map: bit positions, word layout,
 register offsets and reset values. Assumes a 20 MHz main clock.
*/
package vspm_pkg;
	// ==========================================================
	// Bus and word layout
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int AXES = 6;
	localparam int PROGS = 64;
	localparam int VIN_BASE = 7000;
	localparam int VIN_LAST = 7299;
	localparam int VOUT_BASE = 7300;
	localparam int VOUT_LAST = 7599;
	// ==========================================================
	// Virtual input and output bit numbers
	localparam int P_OFF = 7000;
	localparam int P_ON = 7001;
	localparam int P_SYS_LOW = 7002;
	localparam int P_SYS_BAD = 7003;
	localparam int P_ERR_MSG = 7006;
	localparam int P_ERR_CAN = 7007;
	localparam int P_ERR_COLD = 7008;
	localparam int P_CUTOFF = 7010;
	localparam int P_CAN_LATCH = 7011;
	localparam int P_PAUSE = 7012;
	localparam int P_ILOCK = 7013;
	localparam int P_ABS_FIRST = 7015;
	localparam int P_AUTO_MODE = 7071;
	localparam int P_AUTO_RUN = 7072;
	localparam int P_PROG_FIRST = 7101;
	localparam int P_LATCH_CANCEL = 7300;
	// ==========================================================
	// Register word offsets (bytes); word N holds ports BASE+32N..
	localparam logic [ADDR_W-1:0] OFF_VIN0 = 8'h00;
	localparam int VIN_WORDS = 10;
	localparam logic [ADDR_W-1:0] OFF_VOUT0 = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h80;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h84;
	localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;
	// Interrupt status bits
	localparam int IRQ_CAN_SET = 0;
	localparam int IRQ_ABS_BAD = 1;
	localparam int IRQ_CUTOFF = 2;
	localparam int IRQ_W = 3;

	typedef struct packed {
		logic sys_low;
		logic sys_bad;
		logic err_msg;
		logic err_can;
		logic err_cold;
		logic cutoff;
		logic cancel_cause;
		logic pause_cause;
		logic ilock_port;
		logic auto_mode;
		logic auto_run;
	} vspm_status_t;
endpackage

// ### logic/vspm_cancel_latch.sv
/*
 Cancellation latch with self-clearing cancel request.
 Assumes synchronous inputs and a released synchronous-domain reset.
*/
`timescale 1ns/1ps
module vspm_cancel_latch (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Cause and request
	input wire logic cause,
	input wire logic cancel_wr,
	input wire logic cancel_val,
	// State
	output logic latch,
	output logic cancel_bit,
	output logic set_pulse
);
	logic latch_reg, latch_next, req_reg, req_next;

	always_comb begin
		latch_next = latch_reg;
		req_next = req_reg;
		if (req_reg && !cause)
			latch_next = 1'b0;
		if (cause)
			latch_next = 1'b1;
		if (req_reg)
			req_next = 1'b0;
		if (cancel_wr)
			req_next = cancel_val;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= 1'b0;
			req_reg <= 1'b0;
		end else begin
			latch_reg <= latch_next;
			req_reg <= req_next;
		end
	end

	assign latch = latch_reg;
	assign cancel_bit = req_reg;
	assign set_pulse = cause && !latch_reg;

	property p_cause_sets;
		@(posedge clock) disable iff (!rst_n) cause |=> latch_reg;
	endproperty
	a_cause_sets: assert property (p_cause_sets) else $error("latch missed cause");

	property p_clear_blocked;
		@(posedge clock) disable iff (!rst_n) (latch_reg && cause) |=> latch_reg;
	endproperty
	a_clear_blocked: assert property (p_clear_blocked) else $error("latch cleared with cause");

	property p_req_returns;
		@(posedge clock) disable iff (!rst_n) (req_reg && !cancel_wr) |=> !req_reg;
	endproperty
	a_req_returns: assert property (p_req_returns) else $error("cancel bit stuck");

	property p_clear_works;
		@(posedge clock) disable iff (!rst_n) (req_reg && !cause) |=> !latch_reg;
	endproperty
	a_clear_works: assert property (p_clear_works) else $error("latch not cleared");
endmodule // vspm_cancel_latch

// ### logic/vspm_abs_batt.sv
/*
 Per-axis absolute battery bits, one generate loop over axes.
 Abnormal bits are sticky until reset (power-on or software).
*/
`timescale 1ns/1ps
module vspm_abs_batt #(
	parameter int AXES = vspm_pkg::AXES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sw_reset,
	// Axis causes
	input wire logic [AXES-1:0] low,
	input wire logic [AXES-1:0] bad,
	input wire logic [AXES-1:0] axis_valid,
	// Pair bits: bit 2k low, bit 2k+1 abnormal
	output logic [2*AXES-1:0] pairs,
	output logic bad_rise
);
	logic [AXES-1:0] bad_reg, bad_next, rise;

	genvar k;
	generate
		for (k = 0; k < AXES; k++) begin : g_axis
			always_comb begin
				// A cause in the reset cycle still sets the bit
				bad_next[k] = (sw_reset ? 1'b0 : bad_reg[k]) | bad[k];
				rise[k] = bad[k] & ~bad_reg[k];
			end
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n)
					bad_reg[k] <= 1'b0;
				else
					bad_reg[k] <= bad_next[k];
			end
			assign pairs[2*k] = low[k] & axis_valid[k];
			assign pairs[2*k+1] = bad_reg[k] & axis_valid[k];

			property p_sticky;
				@(posedge clock) disable iff (!rst_n) (bad_reg[k] && !sw_reset) |=> bad_reg[k];
			endproperty
			a_sticky: assert property (p_sticky) else $error("abs bad dropped");
		end
	endgenerate

	assign bad_rise = |rise;
endmodule // vspm_abs_batt

// ### logic/vspm_top.sv
/*
 Virtual status port map: status bits for the user program as a
 bit-addressed read-only map, one virtual output bit, and an interrupt.
 Assumes synchronous status inputs from the controller core and a
 single-cycle strobe register port with read data one cycle later.
*/
`timescale 1ns/1ps
// Functional notes
// - System battery low warning and abnormal voltage bits.
// - Bit high while top pending error is message level.
// - Bit high while top pending error is cancellation level.
// - Bit high while top pending error is cold-start level.
// - Drive cutoff bit high while any cutoff cause, including reset wait.
// - Cancellation latch sets on any cause, even one cycle.
// - Program requests clear; cleared only when no cause remains.
// - Latch-cancel bit returns to zero after each attempt.
// - Pause bit high with pause cause, only during automatic operation.
// - Interlock bit is pause cause OR interlock input cause.
// - Per axis a low-warning bit then an abnormal bit.
// - Abnormal axis battery bit sticky until power-on or software reset.
// - Axis 5 and 6 bits valid only for six-axis configuration.
// - One running bit per program, numbered by program number.
module vspm_top #(
	parameter int AXES = vspm_pkg::AXES,
	parameter int PROGS = vspm_pkg::PROGS,
	parameter int AXES_SUPPORTED = 6
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic sw_reset,
	// Controller status
	input wire vspm_pkg::vspm_status_t status,
	input wire logic [AXES-1:0] abs_low,
	input wire logic [AXES-1:0] abs_bad,
	input wire logic [PROGS-1:0] prog_running,
	// Register port
	input wire logic [vspm_pkg::ADDR_W-1:0] addr,
	input wire logic [vspm_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [vspm_pkg::DATA_W-1:0] rdata,
	// Interrupt
	output logic irq
);
	// ==========================================================
	// Reset release
	logic rs1_reg, rs2_reg, rst_n;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rs1_reg <= 1'b0;
			rs2_reg <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rs2_reg <= rs1_reg;
		end
	end
	assign rst_n = rs2_reg;

	// ==========================================================
	// Virtual input vector, index 0 is port 7000
	localparam int NVIN = vspm_pkg::VIN_WORDS * vspm_pkg::DATA_W;
	logic [NVIN-1:0] vin;
	logic [2*AXES-1:0] abs_pairs;
	logic [AXES-1:0] axis_valid;
	logic latch, cancel_bit, can_set, abs_rise, cancel_wr;

	genvar a;
	generate
		for (a = 0; a < AXES; a++) begin : g_valid
			// axes above four need six-axis build
			assign axis_valid[a] = (a < 4) || (AXES_SUPPORTED >= 6);
		end
	endgenerate

	always_comb begin
		vin = '0;
		vin[vspm_pkg::P_OFF - vspm_pkg::VIN_BASE] = 1'b0;
		vin[vspm_pkg::P_ON - vspm_pkg::VIN_BASE] = 1'b1;
		vin[vspm_pkg::P_SYS_LOW - vspm_pkg::VIN_BASE] = status.sys_low;
		vin[vspm_pkg::P_SYS_BAD - vspm_pkg::VIN_BASE] = status.sys_bad;
		vin[vspm_pkg::P_ERR_MSG - vspm_pkg::VIN_BASE] = status.err_msg;
		vin[vspm_pkg::P_ERR_CAN - vspm_pkg::VIN_BASE] = status.err_can;
		vin[vspm_pkg::P_ERR_COLD - vspm_pkg::VIN_BASE] = status.err_cold;
		vin[vspm_pkg::P_CUTOFF - vspm_pkg::VIN_BASE] = status.cutoff;
		vin[vspm_pkg::P_CAN_LATCH - vspm_pkg::VIN_BASE] = latch;
		vin[vspm_pkg::P_PAUSE - vspm_pkg::VIN_BASE] = status.pause_cause & status.auto_run;
		vin[vspm_pkg::P_ILOCK - vspm_pkg::VIN_BASE] = status.pause_cause | status.ilock_port;
		vin[vspm_pkg::P_ABS_FIRST - vspm_pkg::VIN_BASE +: 2*AXES] = abs_pairs;
		vin[vspm_pkg::P_AUTO_MODE - vspm_pkg::VIN_BASE] = status.auto_mode;
		vin[vspm_pkg::P_AUTO_RUN - vspm_pkg::VIN_BASE] = status.auto_run;
		vin[vspm_pkg::P_PROG_FIRST - vspm_pkg::VIN_BASE +: PROGS] = prog_running;
	end

	// ==========================================================
	// Submodules
	assign cancel_wr = wr && (addr == vspm_pkg::OFF_VOUT0);

	vspm_cancel_latch u_latch (
		.clock(clock),
		.rst_n(rst_n),
		.cause(status.cancel_cause),
		.cancel_wr(cancel_wr),
		.cancel_val(wdata[0]),
		.latch(latch),
		.cancel_bit(cancel_bit),
		.set_pulse(can_set)
	);

	vspm_abs_batt #(.AXES(AXES)) u_abs (
		.clock(clock),
		.rst_n(rst_n),
		.sw_reset(sw_reset),
		.low(abs_low),
		.bad(abs_bad),
		.axis_valid(axis_valid),
		.pairs(abs_pairs),
		.bad_rise(abs_rise)
	);

	// ==========================================================
	// Interrupt status and mask
	logic [vspm_pkg::IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next, ev;
	logic cut_d_reg, cut_d_next;
	logic [vspm_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic [3:0] word;

	always_comb begin
		ev = '0;
		ev[vspm_pkg::IRQ_CAN_SET] = can_set;
		ev[vspm_pkg::IRQ_ABS_BAD] = abs_rise;
		ev[vspm_pkg::IRQ_CUTOFF] = status.cutoff & ~cut_d_reg;
		cut_d_next = status.cutoff;
		ist_next = ist_reg;
		// Read clears, but a same-cycle event survives
		if (rd && addr == vspm_pkg::OFF_IRQ_STATUS)
			ist_next = '0;
		ist_next = ist_next | ev;
		imask_next = imask_reg;
		if (wr && addr == vspm_pkg::OFF_IRQ_MASK)
			imask_next = wdata[vspm_pkg::IRQ_W-1:0];
	end

	// ==========================================================
	// Read decode; reserved positions read zero
	always_comb begin
		word = addr[5:2];
		rdata_next = '0;
		if (!rd) begin
			rdata_next = '0;
		end else if (addr < vspm_pkg::OFF_VOUT0 && addr[1:0] == 2'b00
				&& word < 4'(vspm_pkg::VIN_WORDS)) begin
			rdata_next = vin[32*word +: 32];
		end else if (addr == vspm_pkg::OFF_VOUT0) begin
			rdata_next = {31'h00000000, cancel_bit};
		end else if (addr == vspm_pkg::OFF_IRQ_STATUS) begin
			rdata_next = {29'h00000000, ist_reg};
		end else if (addr == vspm_pkg::OFF_IRQ_MASK) begin
			rdata_next = {29'h00000000, imask_reg};
		end else begin
			rdata_next = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ist_reg <= '0;
			imask_reg <= vspm_pkg::MASK_RESET[vspm_pkg::IRQ_W-1:0];
			cut_d_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			ist_reg <= ist_next;
			imask_reg <= imask_next;
			cut_d_reg <= cut_d_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
	assign irq = |(ist_reg & imask_reg);

	property p_interlock;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_ILOCK - vspm_pkg::VIN_BASE] ==
			($past(status.pause_cause) | $past(status.ilock_port));
	endproperty
	a_interlock: assert property (p_interlock) else $error("interlock bit wrong");

	property p_fixed;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=> rdata[1:0] == 2'b10;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed bits wrong");

	property p_pause;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 && !status.auto_run |=>
			!rdata[vspm_pkg::P_PAUSE - vspm_pkg::VIN_BASE];
	endproperty
	a_pause: assert property (p_pause) else $error("pause outside auto");

	property p_cutoff;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_CUTOFF - vspm_pkg::VIN_BASE] == $past(status.cutoff);
	endproperty
	a_cutoff: assert property (p_cutoff) else $error("cutoff bit wrong");

	// ==========================================================
	// Map and interrupt checks
	localparam int AUTO_IDX = vspm_pkg::P_AUTO_MODE - vspm_pkg::VIN_BASE;
	localparam int PROG_IDX = vspm_pkg::P_PROG_FIRST - vspm_pkg::VIN_BASE;
	localparam logic [vspm_pkg::ADDR_W-1:0] AUTO_ADDR =
		vspm_pkg::OFF_VIN0 + 8'((AUTO_IDX / vspm_pkg::DATA_W) * 4);
	localparam logic [vspm_pkg::ADDR_W-1:0] PROG_ADDR =
		vspm_pkg::OFF_VIN0 + 8'((PROG_IDX / vspm_pkg::DATA_W) * 4);

	property p_sys_batt;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_SYS_LOW - vspm_pkg::VIN_BASE +: 2] ==
			{$past(status.sys_bad), $past(status.sys_low)};
	endproperty
	a_sys_batt: assert property (p_sys_batt) else $error("system battery bits wrong");

	property p_err_msg;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_ERR_MSG - vspm_pkg::VIN_BASE] == $past(status.err_msg);
	endproperty
	a_err_msg: assert property (p_err_msg) else $error("message level bit wrong");

	property p_err_can;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_ERR_CAN - vspm_pkg::VIN_BASE] == $past(status.err_can);
	endproperty
	a_err_can: assert property (p_err_can) else $error("cancel level bit wrong");

	property p_err_cold;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_ERR_COLD - vspm_pkg::VIN_BASE] == $past(status.err_cold);
	endproperty
	a_err_cold: assert property (p_err_cold) else $error("cold start bit wrong");

	property p_latch_bit;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_CAN_LATCH - vspm_pkg::VIN_BASE] == $past(latch);
	endproperty
	a_latch_bit: assert property (p_latch_bit) else $error("latch bit wrong");

	property p_axis1_low;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VIN0 |=>
			rdata[vspm_pkg::P_ABS_FIRST - vspm_pkg::VIN_BASE] == $past(abs_low[0]);
	endproperty
	a_axis1_low: assert property (p_axis1_low) else $error("axis low bit wrong");

	property p_auto_bits;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == AUTO_ADDR |=>
			rdata[AUTO_IDX % vspm_pkg::DATA_W +: 2] ==
			{$past(status.auto_run), $past(status.auto_mode)};
	endproperty
	a_auto_bits: assert property (p_auto_bits) else $error("mode bits wrong");

	property p_prog_first;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == PROG_ADDR |=>
			rdata[PROG_IDX % vspm_pkg::DATA_W] == $past(prog_running[0]);
	endproperty
	a_prog_first: assert property (p_prog_first) else $error("program bit wrong");

	property p_cancel_read;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_VOUT0 |=>
			rdata == {31'h00000000, $past(cancel_bit)};
	endproperty
	a_cancel_read: assert property (p_cancel_read) else $error("cancel bit read wrong");

	property p_rdata_idle;
		@(posedge clock) disable iff (!rst_n)
			!rd |=> rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

	property p_ist_clear;
		@(posedge clock) disable iff (!rst_n)
			rd && addr == vspm_pkg::OFF_IRQ_STATUS && ev == '0 |=>
			ist_reg == '0;
	endproperty
	a_ist_clear: assert property (p_ist_clear) else $error("status not cleared by read");

	property p_ist_set;
		@(posedge clock) disable iff (!rst_n)
			ev != '0 |=>
			(ist_reg & $past(ev)) == $past(ev);
	endproperty
	a_ist_set: assert property (p_ist_set) else $error("event lost from status");

	property p_mask_write;
		@(posedge clock) disable iff (!rst_n)
			wr && addr == vspm_pkg::OFF_IRQ_MASK |=>
			imask_reg == $past(wdata[vspm_pkg::IRQ_W-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");
endmodule // vspm_top

// ### dv/vspm_top_tb.sv
/*
 Self-checking bench for the virtual status port map top.
 Assumes the one-cycle strobe register port and map of the package.
*/
`timescale 1ns/1ps
module vspm_top_tb;
	// ==========================================================
	// Stimulus signals
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic sw_reset = 1'b0;
	vspm_pkg::vspm_status_t status = '0;
	logic [5:0] abs_low = 6'h00;
	logic [5:0] abs_bad = 6'h00;
	logic [63:0] prog_running = 64'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic irq;
	int errors = 0;
	int checked = 0;

	always #25 clock = ~clock;

	vspm_top vspm_top_inst (
		.clock(clock),
		.arst_n(arst_n),
		.sw_reset(sw_reset),
		.status(status),
		.abs_low(abs_low),
		.abs_bad(abs_bad),
		.prog_running(prog_running),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.irq(irq)
	);

	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// Write then read with no gap, to see a one-cycle bit
	task automatic wr_rd_chk(input string n, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask

	task automatic finish_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_status();
		@(posedge clock);
		status <= 11'b101_01_0_0_1_0_1_0;
		rd_chk("word0 a", 8'h00, 32'h00002146);
		rd_chk("word2 a", 8'h08, 32'h00000080);
		status <= 11'b010_10_1_0_1_0_0_1;
		rd_chk("word0 b", 8'h00, 32'h0000348A);
		rd_chk("word2 b", 8'h08, 32'h00000100);
		status <= 11'b000_00_0_0_0_1_0_0;
		rd_chk("word0 c", 8'h00, 32'h00002002);
		status <= '0;
	endtask

	task automatic t_latch();
		@(posedge clock);
		status.cancel_cause <= 1'b1;
		@(posedge clock);
		status.cancel_cause <= 1'b0;
		rd_chk("latch set", 8'h00, 32'h00000802);
		status.cancel_cause <= 1'b1;
		wr_rd_chk("cancel bit set", 8'h40, 32'h00000001, 32'h00000001);
		rd_chk("cancel bit", 8'h40, 32'h00000000);
		rd_chk("latch held", 8'h00, 32'h00000802);
		status.cancel_cause <= 1'b0;
		wr_reg(8'h40, 32'h00000001);
		rd_chk("latch clear", 8'h00, 32'h00000002);
		rd_chk("cancel bit 2", 8'h40, 32'h00000000);
	endtask

	task automatic t_axes();
		@(posedge clock);
		abs_low <= 6'h15;
		abs_bad <= 6'h2A;
		rd_chk("axis pairs", 8'h00, 32'h04CC8002);
		abs_low <= 6'h00;
		abs_bad <= 6'h00;
		rd_chk("axis sticky", 8'h00, 32'h04440002);
		sw_reset <= 1'b1;
		@(posedge clock);
		sw_reset <= 1'b0;
		rd_chk("axis cleared", 8'h00, 32'h00000002);
	endtask

	task automatic t_progs();
		int p;
		int idx;
		for (int i = 0; i < 3; i++) begin
			p = (i == 0) ? 1 : (i == 1) ? 32 : 64;
			idx = 100 + p;
			@(posedge clock);
			prog_running <= 64'h1 << (p - 1);
			rd_chk("prog bit", 8'((idx / 32) * 4), 32'h1 << (idx % 32));
		end
		prog_running <= 64'h0;
		rd_chk("reserved word", 8'h18, 32'h00000000);
		rd_chk("unmapped", 8'hFC, 32'h00000000);
	endtask

	task automatic t_irq();
		// Earlier scenarios left events pending; flush them first
		@(posedge clock);
		rd <= 1'b1;
		addr <= 8'h80;
		@(posedge clock);
		rd <= 1'b0;
		wr_reg(8'h84, 32'h00000001);
		rd_chk("mask", 8'h84, 32'h00000001);
		chk("irq idle", 32'h0, {31'h0, irq});
		status.cancel_cause <= 1'b1;
		@(posedge clock);
		status.cancel_cause <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk("irq raised", 32'h1, {31'h0, irq});
		rd_chk("irq status", 8'h80, 32'h00000001);
		chk("irq cleared", 32'h0, {31'h0, irq});
		@(posedge clock);
		abs_bad <= 6'h01;
		repeat (3) @(posedge clock);
		#1 chk("irq masked", 32'h0, {31'h0, irq});
		rd_chk("irq status 2", 8'h80, 32'h00000002);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk("reset rdata", 32'h0, rdata);
		chk("reset irq", 32'h0, {31'h0, irq});
		rd_chk("fixed bits", 8'h00, 32'h00000002);
		t_status();
		t_latch();
		t_axes();
		t_progs();
		t_irq();
		finish_test();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		finish_test();
	end
endmodule // vspm_top_tb
